/* sum_defs.svh */
// Constants for the supply undervoltage monitor
`ifndef SUM_DEFS_SVH
`define SUM_DEFS_SVH
`define SUM_ADDR_STATUS 16'hFE0F
`define SUM_ADDR_OPTION 16'h001F
`define SUM_ADDR_RSTSRC 16'hFE01
`define SUM_ADDR_IRQSTAT 16'hFE20
`define SUM_ADDR_IRQMASK 16'hFE24
`define SUM_BIT_FLAG 7
`define SUM_BIT_PWR 0
`define SUM_BIT_RST 1
`define SUM_BIT_STOP 2
`define SUM_BIT_RSTSRC 1
`define SUM_BIT_IRQ 0
`define SUM_OPTION_RESET 8'h00
`define SUM_CPU_FILTER 4'h9
`define SUM_XTAL_FILTER 6'h24
`define SUM_SYNC_STAGES 2
`endif

/* sum_pkg.sv */
// Types for the supply undervoltage monitor
`default_nettype none
package sum_pkg;
  typedef struct packed {
    logic powerEnableN;
    logic tripResetEnableN;
    logic stopModeMonitorEnableN;
  } sum_option_t;
  typedef enum logic [1:0] {
    SUM_IDLE = 2'b00,
    SUM_FILTER = 2'b01,
    SUM_HOLD = 2'b11
  } sum_state_t;
endpackage
`default_nettype wire

/* sum_sync.sv */
// Two-stage synchroniser for the comparator level
`timescale 1ns/1ps
`default_nettype none
module sum_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* sum_count.sv */
// Saturating filter counter, restarts when the condition drops
`timescale 1ns/1ps
`default_nettype none
module sum_count #(
  parameter int W = 6
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire logic cond,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  assign cnt_next = !cond ? '0 : (tick && cnt_reg != limit) ? W'(cnt_reg + 1'b1) : cnt_reg;
  assign done = cond && (cnt_reg == limit);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* sum_monitor.sv */
// Supply undervoltage monitor: filters, flag, reset hold and APB registers
// How it works
// - Monitor is enabled right out of reset, no software needed.
// - Power, reset and stop enables come from the option register.
// - Monitoring runs only while the power enable bit is zero.
// - Reset enable bit at one suppresses monitor resets; flag still works.
// - Reset raised after nine consecutive CPU cycles at or below falling level.
// - Once in reset, hold until supply reported above rising level.
// - One CPU cycle above rising level releases the reset.
// - External reset pin driven low during a monitor reset.
// - Comparator drives the low supply flag while monitoring runs, resets or not.
// - Flag sets after 36 crystal cycles below falling level.
// - Flag clears above rising level, holds between the two levels.
// - Status bit 7 is the flag, others zero, writes ignored.
// - No interrupt request is ever made by the monitor; here irq rises on a monitor reset while the mask bit is set.
// - Monitoring stays on in wait mode; reset ends wait mode.
// - Stop mode keeps monitoring only when stop and power enables zero.
// - Power enable zero and stop enable one disables stop monitoring.
// - In stop mode a trip bypasses the cycle filter to reset.
// - Monitor resets set the reset source bit, cleared on read.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sum_defs.svh"
module sum_monitor
  import sum_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic xtalTick,
  input wire logic belowFalling,
  input wire logic aboveRising,
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic monitorReset,
  output logic resetPinOut,
  output logic resetPinOe,
  output logic wakeRequest,
  output logic irq
);
  sum_option_t option_reg;
  sum_state_t state_reg;
  sum_state_t state_next;
  logic flag_reg;
  logic flag_next;
  logic srcBit_reg;
  logic irqStat_reg;
  logic irqMask_reg;
  logic [31:0] prdata_reg;
  logic belowSync;
  logic aboveSync;
  logic monitorActive;
  logic resetEnabled;
  logic cpuDone;
  logic xtalDone;
  logic cpuTick;
  logic tripNow;
  logic fire;

  sum_sync u_sync_below (.clock(clock), .rst(rst), .din(belowFalling), .dout(belowSync));
  sum_sync u_sync_above (.clock(clock), .rst(rst), .din(aboveRising), .dout(aboveSync));

  assign monitorActive = !option_reg.powerEnableN
                         && (!stopMode || !option_reg.stopModeMonitorEnableN);
  assign resetEnabled = monitorActive && !option_reg.tripResetEnableN;
  assign cpuTick = !stopMode;

  sum_count #(.W(4)) u_cpu_filter (
    .clock(clock), .rst(rst), .tick(cpuTick), .cond(belowSync && monitorActive),
    .limit(4'(`SUM_CPU_FILTER - 1)), .done(cpuDone)
  );
  sum_count #(.W(6)) u_xtal_filter (
    .clock(clock), .rst(rst), .tick(xtalTick), .cond(belowSync && monitorActive),
    .limit(`SUM_XTAL_FILTER), .done(xtalDone)
  );

  assign tripNow = resetEnabled && belowSync && (stopMode || cpuDone);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SUM_IDLE: begin
        if (resetEnabled && belowSync) begin
          state_next = SUM_FILTER;
        end
      end
      SUM_FILTER: begin
        if (tripNow) begin
          state_next = SUM_HOLD;
        end else if (!(resetEnabled && belowSync)) begin
          state_next = SUM_IDLE;
        end
      end
      SUM_HOLD: begin
        if (aboveSync) begin
          state_next = SUM_IDLE;
        end
      end
      default: state_next = SUM_IDLE;
    endcase
  end
  assign fire = (state_reg != SUM_HOLD) && (state_next == SUM_HOLD);

  assign flag_next = aboveSync ? 1'b0 : (xtalDone ? 1'b1 : flag_reg);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= SUM_IDLE;
      flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      flag_reg <= flag_next;
    end
  end

  assign monitorReset = (state_reg == SUM_HOLD);
  assign resetPinOut = 1'b0;
  assign resetPinOe = monitorReset;
  assign wakeRequest = monitorReset && (waitMode || stopMode);

  // APB decode
  logic wrEn;
  logic rdEn;
  logic hitStatus;
  logic hitOption;
  logic hitSrc;
  logic hitIrqStat;
  logic hitIrqMask;
  logic hitAny;
  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign hitStatus = (paddr == `SUM_ADDR_STATUS);
  assign hitOption = (paddr == `SUM_ADDR_OPTION);
  assign hitSrc = (paddr == `SUM_ADDR_RSTSRC);
  assign hitIrqStat = (paddr == `SUM_ADDR_IRQSTAT);
  assign hitIrqMask = (paddr == `SUM_ADDR_IRQMASK);
  assign hitAny = hitStatus || hitOption || hitSrc || hitIrqStat || hitIrqMask;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hitAny;
  assign prdata = prdata_reg;

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    // Flag at bit 7, rest zero
    if (hitStatus) begin
      rdMux[`SUM_BIT_FLAG] = flag_reg;
    end else if (hitOption) begin
      rdMux[`SUM_BIT_PWR] = option_reg.powerEnableN;
      rdMux[`SUM_BIT_RST] = option_reg.tripResetEnableN;
      rdMux[`SUM_BIT_STOP] = option_reg.stopModeMonitorEnableN;
    end else if (hitSrc) begin
      rdMux[`SUM_BIT_RSTSRC] = srcBit_reg;
    end else if (hitIrqStat) begin
      rdMux[`SUM_BIT_IRQ] = irqStat_reg;
    end else if (hitIrqMask) begin
      rdMux[`SUM_BIT_IRQ] = irqMask_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      option_reg <= sum_option_t'(3'(`SUM_OPTION_RESET));
      prdata_reg <= 32'h00000000;
    end else begin
      if (wrEn && hitOption) begin
        option_reg.powerEnableN <= pwdata[`SUM_BIT_PWR];
        option_reg.tripResetEnableN <= pwdata[`SUM_BIT_RST];
        option_reg.stopModeMonitorEnableN <= pwdata[`SUM_BIT_STOP];
      end
      if (psel && !penable && !pwrite) begin
        prdata_reg <= rdMux;
      end
    end
  end

  // Source bit, set wins over read clear
  // Chip reset clears it here; system keeps it across monitor resets
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      srcBit_reg <= 1'b0;
      irqStat_reg <= 1'b0;
      irqMask_reg <= 1'b0;
    end else begin
      if (fire) begin
        srcBit_reg <= 1'b1;
      end else if (rdEn && hitSrc) begin
        srcBit_reg <= 1'b0;
      end
      if (fire) begin
        irqStat_reg <= 1'b1;
      end else if (wrEn && hitIrqStat && pwdata[`SUM_BIT_IRQ]) begin
        irqStat_reg <= 1'b0;
      end
      if (wrEn && hitIrqMask) begin
        irqMask_reg <= pwdata[`SUM_BIT_IRQ];
      end
    end
  end

  // Monitor itself requests none; optional bus-side event only
  assign irq = irqStat_reg && irqMask_reg;
endmodule
`default_nettype wire

/* sum_monitor_sva.sv */
// Port checker for the supply monitor
`timescale 1ns/1ps
`default_nettype none
`include "sum_defs.svh"
module sum_monitor_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic belowFalling,
  input wire logic aboveRising,
  input wire logic waitMode,
  input wire logic stopMode,
  input wire logic monitorReset,
  input wire logic resetPinOut,
  input wire logic resetPinOe,
  input wire logic wakeRequest
);
  logic [2:0] optReg;
  logic [4:0] belowCnt;
  // Shadow of the option bits, seen from bus writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      optReg <= 3'h0;
      belowCnt <= 5'h00;
    end else begin
      if (psel && penable && pwrite && pready && paddr == `SUM_ADDR_OPTION) optReg <= pwdata[2:0];
      belowCnt <= !belowFalling ? 5'h00 : belowCnt + 5'(belowCnt != 5'h1F);
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_pin; monitorReset |-> resetPinOe && !resetPinOut; endproperty
  a_pin: assert property (p_pin) else $error("pin idle");
  property p_rel; aboveRising [*4] |=> !monitorReset; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_hold; (!aboveRising) [*3] ##0 monitorReset |=> monitorReset; endproperty
  a_hold: assert property (p_hold) else $error("early release");
  property p_short; !monitorReset && !stopMode && $rose(belowFalling) |=> !monitorReset [*8];
  endproperty
  a_short: assert property (p_short) else $error("early reset");
  property p_long; belowCnt == 5'h10 && optReg[1:0] == 2'h0 && !(stopMode && optReg[2])
    |-> monitorReset; endproperty
  a_long: assert property (p_long) else $error("missing reset");
  property p_off; optReg[1:0] != 2'h0 |-> !$rose(monitorReset); endproperty
  a_off: assert property (p_off) else $error("reset while off");
  property p_stop; stopMode && optReg[2] |-> !$rose(monitorReset); endproperty
  a_stop: assert property (p_stop) else $error("stop reset");
  property p_wake; $rose(monitorReset) && waitMode |-> wakeRequest; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_stat; psel && penable && !pwrite && paddr == `SUM_ADDR_STATUS
    |-> pready && prdata[6:0] == 7'h00; endproperty
  a_stat: assert property (p_stat) else $error("status bits");
endmodule
bind sum_monitor sum_monitor_sva i_sva (.clock, .rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .belowFalling, .aboveRising, .waitMode, .stopMode,
  .monitorReset, .resetPinOut, .resetPinOe, .wakeRequest);
`default_nettype wire

/* sum_supply_model.sv */
// Comparator and crystal tick model
`timescale 1ns/1ps
`default_nettype none
module sum_supply_model (
  input wire logic clock,
  input wire logic [1:0] lvl,
  output logic xtalTick,
  output logic belowFalling,
  output logic aboveRising
);
  logic [1:0] div = 2'h0;
  // Crystal at a quarter rate, so counts stay short
  always @(posedge clock) div <= div + 2'h1;
  assign xtalTick = (div == 2'h3);
  // Level 0 low, 1 between trip levels, 2 good; hysteresis keeps both low in between
  assign belowFalling = (lvl == 2'h0);
  assign aboveRising = (lvl == 2'h2);
endmodule
`default_nettype wire

/* sum_monitor_tb_top.sv */
// Testbench for the supply monitor
`timescale 1ns/1ps
`default_nettype none
`include "sum_defs.svh"
module sum_monitor_tb_top;
  logic clock, rst, waitMode, stopMode, psel, penable, pwrite, pready, pslverr, er;
  logic monitorReset, resetPinOut, resetPinOe, wakeRequest, irq;
  logic xtalTick, belowFalling, aboveRising;
  logic [1:0] lvl;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] e;
  logic [5:0] tab [5] = '{6'h02, 6'h01, 6'h28, 6'h14, 6'h30};
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  sum_supply_model i_sup (.clock, .lvl, .xtalTick, .belowFalling, .aboveRising);
  sum_monitor i_dut (.clock, .rst, .xtalTick, .belowFalling, .aboveRising, .waitMode,
    .stopMode, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .monitorReset, .resetPinOut, .resetPinOe, .wakeRequest, .irq);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  // Hang guard, far above the roughly 1330 cycles needed
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    {rst, waitMode, stopMode, psel, penable, pwrite, paddr, pwdata, lvl} = {1'b1, 53'h0, 2'h2};
    wt(4);
    rst <= 1'b0;
    apb(0, `SUM_ADDR_STATUS, 0); chk("status", rd, 0);
    apb(1, `SUM_ADDR_STATUS, 32'hFF); apb(0, `SUM_ADDR_STATUS, 0); chk("wr", rd, 0);
    apb(0, 16'h0100, 0); chk("unmapped", 32'(er), 1);
    lvl <= 2'h0; wt(6); lvl <= 2'h2; wt(4);
    chk("dip", 32'(monitorReset), 0);
    lvl <= 2'h0; wt(200);
    chk("trip", 32'(monitorReset), 1);
    chk("pin", 32'(resetPinOe), 1);
    chk("pin level", 32'(resetPinOut), 0);
    apb(0, `SUM_ADDR_STATUS, 0); chk("flag", rd, 32'h80);
    lvl <= 2'h1; wt(20);
    chk("hold", 32'(monitorReset), 1);
    apb(0, `SUM_ADDR_STATUS, 0); chk("keep", rd, 32'h80);
    lvl <= 2'h2; wt(5);
    chk("release", 32'(monitorReset), 0);
    apb(0, `SUM_ADDR_STATUS, 0); chk("clear", rd, 0);
    apb(0, `SUM_ADDR_RSTSRC, 0); chk("source", rd, 32'h2);
    apb(0, `SUM_ADDR_RSTSRC, 0); chk("source rd", rd, 0);
    chk("masked", 32'(irq), 0);
    apb(1, `SUM_ADDR_IRQMASK, 1); chk("irq", 32'(irq), 1);
    apb(1, `SUM_ADDR_IRQSTAT, 1); chk("irq clr", 32'(irq), 0);
    // Rows: option bits, wait, stop, expected reset
    for (int i = 0; i < 5; i++) begin
      e = tab[i];
      apb(1, `SUM_ADDR_OPTION, {29'h0, e[2:0]});
      waitMode <= e[3];
      stopMode <= e[4];
      lvl <= 2'h0;
      wt(200);
      chk("mode", 32'(monitorReset), 32'(e[5]));
      chk("wake", 32'(wakeRequest), 32'(e[5]));
      if (!e[4]) begin
        apb(0, `SUM_ADDR_STATUS, 0); chk("mflag", rd, {24'h0, ~e[0], 7'h0});
      end
      waitMode <= 1'b0;
      stopMode <= 1'b0;
      lvl <= 2'h2;
      wt(6);
    end
    stop_test;
  end
endmodule
`default_nettype wire
